// ===== src/scs_pkg.sv
// Purpose: Shared constants and types for the clock-stop serial port
// Assumes: 50 MHz system clock feeds the block
// Notes: Timing figures are kept in their own units; counts derive from them

package scs_pkg;

   // ==========
   // Clock and bit-rate limits
   // ==========
   localparam int CPU_PERIOD_NS = 20;
   localparam int MAX_BIT_RATE_MBPS = 100;
   localparam int MIN_BIT_PERIOD_NS = 1000 / MAX_BIT_RATE_MBPS;
   // Least bit period in system clocks, rounded up
   localparam int MIN_BIT_CYCLES_RATE = (MIN_BIT_PERIOD_NS + CPU_PERIOD_NS - 1) / CPU_PERIOD_NS;
   // Never faster than half the system clock
   localparam int MIN_BIT_CYCLES = (MIN_BIT_CYCLES_RATE > 2) ? MIN_BIT_CYCLES_RATE : 2;
   localparam int MIN_DIVIDE = MIN_BIT_CYCLES - 1;

   // ==========
   // Default sizes
   // ==========
   localparam int WORD_BITS_DEF = 8;
   localparam int DIV_WIDTH_DEF = 8;
   localparam int FIFO_DEPTH_DEF = 8;

   // ==========
   // Mode codes and forced slave settings
   // ==========
   localparam logic [1:0] MODE_NO_DELAY = 2'h2;
   localparam logic [1:0] MODE_HALF_DELAY = 2'h3;
   localparam logic SLAVE_SOURCE_SELECT = 1'h1;
   localparam int SLAVE_DIVIDE = 1;

   // ==========
   // Reset values
   // ==========
   localparam logic RST_PIN_LEVEL = 1'h0;
   localparam logic RST_PIN_OE = 1'h0;

   // ==========
   // Sequencer states
   // ==========
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ARM = 4'h2,
      ST_MASTER = 4'h4,
      ST_SLAVE = 4'h8
   } scs_state_t;

endpackage : scs_pkg

// ===== src/scs_rate_gen.sv
// Purpose: Sample-rate generator producing the internal bit clock
// Assumes: External rate clock pin is synchronous to clk
// Notes: Divide value below one is raised to one by the caller

`timescale 1ns/1ps
`default_nettype none

module scs_rate_gen #(
   parameter int DIV_W = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic src_sel,
   input wire logic [DIV_W-1:0] divide,
   input wire logic ext_clk,
   output logic level_ff,
   output logic rise_ff,
   output logic fall_ff
);

   // ==========================================================
   // Elaboration check
   // ==========================================================
   if (DIV_W < 2) begin : g_bad_width
      $error("divide width too small");
   end

   logic ext_prev_ff;
   logic [DIV_W-1:0] cnt_ff;
   wire logic tick;
   wire logic [DIV_W:0] div_plus;
   wire logic [DIV_W:0] high_len;
   wire logic [DIV_W:0] cnt_plus;
   wire logic wrap;
   wire logic fall_hit;

   // Input clock: every system clock or each rising edge of the pin
   assign tick = src_sel | (ext_clk & ~ext_prev_ff);
   assign div_plus = {1'b0, divide} + {{DIV_W{1'b0}}, 1'b1};
   // High phase length; low phase is the rest of the period
   assign high_len = divide[0] ? (div_plus >> 1) : ({1'b0, divide >> 1} + {{DIV_W{1'b0}}, 1'b1});
   assign cnt_plus = {1'b0, cnt_ff} + {{DIV_W{1'b0}}, 1'b1};
   assign wrap = (cnt_ff == divide);
   assign fall_hit = (cnt_plus == high_len);

   // Period counter, level and edge pulses
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ext_prev_ff <= 1'b0;
         cnt_ff <= '0;
         level_ff <= 1'b1;
         rise_ff <= 1'b0;
         fall_ff <= 1'b0;
      end
      else if (ce)
      begin
         ext_prev_ff <= ext_clk;
         rise_ff <= tick & wrap;
         fall_ff <= tick & ~wrap & fall_hit;
         if (tick & wrap)
         begin
            cnt_ff <= '0;
            level_ff <= 1'b1;
         end
         else if (tick)
         begin
            cnt_ff <= cnt_plus[DIV_W-1:0];
            if (fall_hit)
               level_ff <= 1'b0;
         end
      end
   end

endmodule : scs_rate_gen

`default_nettype wire

// ===== src/scs_fifo.sv
// Purpose: Small synchronous FIFO holding transmit words
// Assumes: One clock; pushes and pops may meet in one cycle
// Notes: Flags are registered so ports come from flip-flops

`timescale 1ns/1ps
`default_nettype none

module scs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready_ff,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid_ff,
   input wire logic out_ready
);

   // ==========================================================
   // Elaboration check
   // ==========================================================
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
      $error("fifo depth must be a power of two");
   end

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ff;
   logic [AW-1:0] rd_ff;
   logic [AW:0] count_ff;
   wire logic push;
   wire logic pop;
   wire logic [AW:0] nxt_count;

   assign push = in_valid & in_ready_ff;
   assign pop = out_valid_ff & out_ready;
   assign nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
   assign out_data = mem[rd_ff];

   // Storage has no reset; only words behind valid are read
   always_ff @(posedge clk)
   begin
      if (ce && push)
         mem[wr_ff] <= in_data;
   end

   // Pointers and registered flags
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_ff <= '0;
         rd_ff <= '0;
         count_ff <= '0;
         in_ready_ff <= 1'b1;
         out_valid_ff <= 1'b0;
      end
      else if (ce)
      begin
         wr_ff <= wr_ff + AW'(push);
         rd_ff <= rd_ff + AW'(pop);
         count_ff <= nxt_count;
         in_ready_ff <= (nxt_count != (AW+1)'(DEPTH));
         out_valid_ff <= (nxt_count != '0);
      end
   end

endmodule : scs_fifo

`default_nettype wire

// ===== src/scs_spi_top.sv
// Purpose: Clock-stop (SPI style) serial port, master or slave
// Assumes: All pins synchronous to clk; three-state pins split in o/oe
// Notes: MSB first; rx words have no back-pressure

`timescale 1ns/1ps
`default_nettype none

module scs_spi_top #(
   parameter int WORD_BITS = scs_pkg::WORD_BITS_DEF,
   parameter int DIV_W = scs_pkg::DIV_WIDTH_DEF,
   parameter int FIFO_DEPTH = scs_pkg::FIFO_DEPTH_DEF
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic port_enable,
   input wire logic [1:0] clock_halt_mode,
   input wire logic tx_clock_polarity,
   input wire logic tx_clock_direction,
   input wire logic rx_clock_direction,
   input wire logic tx_sync_direction,
   input wire logic rx_sync_direction,
   input wire logic tx_sync_polarity,
   input wire logic rx_sync_polarity,
   input wire logic rate_gen_source_select,
   input wire logic [DIV_W-1:0] clock_divide_value,
   input wire logic ext_rate_clock_pin,
   input wire logic [WORD_BITS-1:0] tx_word,
   input wire logic tx_word_valid,
   output logic tx_word_ready,
   output logic [WORD_BITS-1:0] rx_word,
   output logic rx_word_valid,
   output logic busy,
   output logic config_error,
   input wire logic serial_receive_pin,
   output logic serial_transmit_pin_o,
   output logic serial_transmit_pin_oe,
   input wire logic tx_bit_clock_pin_i,
   output logic tx_bit_clock_pin_o,
   output logic tx_bit_clock_pin_oe,
   input wire logic tx_frame_sync_pin_i,
   output logic tx_frame_sync_pin_o,
   output logic tx_frame_sync_pin_oe,
   input wire logic rx_bit_clock_pin,
   input wire logic rx_frame_sync_pin
);

   // ==========
   // Elaboration check and local sizes
   // ==========
   if (WORD_BITS < 2 || DIV_W < 2) begin : g_bad_size
      $error("word or divide width too small");
   end

   localparam int EC_W = $clog2(2 * WORD_BITS + 3);
   localparam int BC_W = $clog2(WORD_BITS + 1);
   localparam logic [EC_W-1:0] E_ONE = EC_W'(1);
   localparam logic [EC_W-1:0] E_TWO = EC_W'(2);
   localparam logic [EC_W-1:0] E_LAST_SMP = EC_W'(2 * WORD_BITS);
   localparam logic [EC_W-1:0] E_FLOAT = EC_W'(2 * WORD_BITS + 1);
   localparam logic [BC_W-1:0] B_ALL = BC_W'(WORD_BITS);
   localparam logic [BC_W-1:0] B_LAST = BC_W'(WORD_BITS - 1);
   localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(scs_pkg::MIN_DIVIDE);
   localparam logic [DIV_W-1:0] DIV_SLAVE = DIV_W'(scs_pkg::SLAVE_DIVIDE);

   // ==========
   // Reset release through two flip-flops
   // ==========
   logic rst_s1_ff;
   logic rst_n_ff;

   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_s1_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end
      else
      begin
         rst_s1_ff <= 1'b1;
         rst_n_ff <= rst_s1_ff;
      end
   end

   // ==========
   // Configuration decode
   // ==========
   wire logic cfg_master;
   wire logic cfg_slave;
   wire logic run_master;
   wire logic run_slave;
   wire logic half_mode;
   wire logic pol;

   assign cfg_master = tx_clock_direction & tx_sync_direction & ~rx_clock_direction & ~rx_sync_direction;
   assign cfg_slave = ~(tx_clock_direction | tx_sync_direction | rx_clock_direction | rx_sync_direction);
   assign run_master = port_enable & clock_halt_mode[1] & cfg_master;
   assign run_slave = port_enable & clock_halt_mode[1] & cfg_slave;
   assign half_mode = (clock_halt_mode == scs_pkg::MODE_HALF_DELAY);
   assign pol = tx_clock_polarity;

   // ==========
   // Rate generator; slave pins it at half the system clock
   // ==========
   wire logic rg_sel;
   wire logic [DIV_W-1:0] rg_div;
   wire logic generated_rate_clock_level;
   wire logic generated_rate_clock_rise;
   wire logic generated_rate_clock_fall;

   assign rg_sel = run_slave ? scs_pkg::SLAVE_SOURCE_SELECT : rate_gen_source_select;
   // Too small a divider would break the rate limit, so it is raised
   assign rg_div = run_slave ? DIV_SLAVE :
                   (clock_divide_value < DIV_MIN) ? DIV_MIN : clock_divide_value;

   scs_rate_gen #(
      .DIV_W(DIV_W)
   ) u_rate_gen (
      .clk(clk),
      .rst_n(rst_n_ff),
      .ce(ce),
      .src_sel(rg_sel),
      .divide(rg_div),
      .ext_clk(ext_rate_clock_pin),
      .level_ff(generated_rate_clock_level),
      .rise_ff(generated_rate_clock_rise),
      .fall_ff(generated_rate_clock_fall)
   );

   // ==========
   // Transmit word buffer
   // ==========
   wire logic [WORD_BITS-1:0] fifo_data;
   wire logic fifo_valid;
   logic fifo_pop;

   scs_fifo #(
      .WIDTH(WORD_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n_ff),
      .ce(ce),
      .in_data(tx_word),
      .in_valid(tx_word_valid),
      .in_ready_ff(tx_word_ready),
      .out_data(fifo_data),
      .out_valid_ff(fifo_valid),
      .out_ready(fifo_pop)
   );

   // ==========
   // Slave pin sampling on the generated clock
   // ==========
   logic xclk_s_ff;
   logic xclk_p_ff;
   logic rclk_s_ff;
   logic rclk_p_ff;
   logic fsx_s_ff;
   logic fsr_s_ff;
   logic dr_s_ff;
   logic evt_ff;

   // Slower sampling trades top slave bit rate for a fixed cadence
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         {xclk_s_ff, xclk_p_ff, rclk_s_ff, rclk_p_ff} <= 4'h0;
         {fsx_s_ff, fsr_s_ff, dr_s_ff, evt_ff} <= 4'h0;
      end
      else if (ce)
      begin
         evt_ff <= generated_rate_clock_rise;
         if (generated_rate_clock_rise)
         begin
            xclk_s_ff <= tx_bit_clock_pin_i;
            xclk_p_ff <= xclk_s_ff;
            rclk_s_ff <= rx_bit_clock_pin;
            rclk_p_ff <= rclk_s_ff;
            fsx_s_ff <= tx_frame_sync_pin_i;
            fsr_s_ff <= rx_frame_sync_pin;
            dr_s_ff <= serial_receive_pin;
         end
      end
   end

   // ==========
   // Edge decode: lead goes away from idle level, trail returns
   // ==========
   logic [BC_W-1:0] bit_cnt_ff;
   wire logic m_lead;
   wire logic m_trail;
   wire logic m_start;
   wire logic sel_tx;
   wire logic sel_rx;
   wire logic x_lead;
   wire logic x_trail;
   wire logic r_lead;
   wire logic r_trail;
   wire logic s_sample;
   wire logic s_shift;

   assign m_lead = pol ? generated_rate_clock_fall : generated_rate_clock_rise;
   assign m_trail = pol ? generated_rate_clock_rise : generated_rate_clock_fall;
   // Half-delay starts on a lead edge, a full period before the first bit edge
   assign m_start = half_mode ? m_lead : m_trail;
   assign sel_tx = fsx_s_ff ^ tx_sync_polarity;
   assign sel_rx = fsr_s_ff ^ rx_sync_polarity;
   assign x_lead = evt_ff & (xclk_s_ff != xclk_p_ff) & (xclk_s_ff != pol);
   assign x_trail = evt_ff & (xclk_s_ff != xclk_p_ff) & (xclk_s_ff == pol);
   assign r_lead = evt_ff & (rclk_s_ff != rclk_p_ff) & (rclk_s_ff != pol);
   assign r_trail = evt_ff & (rclk_s_ff != rclk_p_ff) & (rclk_s_ff == pol);
   assign s_sample = half_mode ? r_lead : r_trail;
   assign s_shift = half_mode ? x_trail : (x_lead & (bit_cnt_ff != '0));

   // ==========
   // Master edge counting
   // ==========
   logic [EC_W-1:0] edge_cnt_ff;
   wire logic [EC_W-1:0] e_n;
   wire logic in_win;
   wire logic [WORD_BITS-1:0] tx_first;

   assign e_n = edge_cnt_ff + E_ONE;
   // Clock runs only inside the word window, idle level elsewhere
   assign in_win = half_mode ? (e_n >= E_TWO && e_n <= E_FLOAT) :
                               (e_n >= E_ONE && e_n <= E_LAST_SMP);
   assign tx_first = fifo_valid ? fifo_data : '0;

   // ==========
   // Sequencer next state
   // ==========
   scs_pkg::scs_state_t state_ff;
   scs_pkg::scs_state_t nxt_state;
   logic [WORD_BITS-1:0] tx_sh_ff;
   logic [WORD_BITS-1:0] nxt_tx_sh;
   logic [WORD_BITS-1:0] rx_sh_ff;
   logic [WORD_BITS-1:0] nxt_rx_sh;
   logic [WORD_BITS-1:0] nxt_rx_word;
   logic [EC_W-1:0] nxt_edge;
   logic [BC_W-1:0] nxt_bits;
   logic dx_ff;
   logic nxt_dx;
   logic nxt_dx_oe;
   logic fs_act_ff;
   logic nxt_fs_act;
   logic nxt_sclk;
   logic nxt_rx_valid;

   always_comb
   begin
      nxt_state = state_ff;
      nxt_tx_sh = tx_sh_ff;
      nxt_rx_sh = rx_sh_ff;
      nxt_rx_word = rx_word;
      nxt_edge = edge_cnt_ff;
      nxt_bits = bit_cnt_ff;
      nxt_dx = dx_ff;
      nxt_dx_oe = serial_transmit_pin_oe;
      nxt_fs_act = fs_act_ff;
      nxt_sclk = tx_bit_clock_pin_o;
      nxt_rx_valid = 1'b0;
      fifo_pop = 1'b0;
      unique case (state_ff)
         scs_pkg::ST_IDLE:
         begin
            nxt_sclk = pol;
            nxt_fs_act = 1'b0;
            nxt_dx_oe = 1'b0;
            if (run_master && fifo_valid)
               nxt_state = scs_pkg::ST_ARM;
            else if (run_slave && sel_tx)
            begin
               // Slave presents its first bit as soon as it is selected
               fifo_pop = fifo_valid;
               nxt_dx = tx_first[WORD_BITS-1];
               nxt_tx_sh = tx_first << 1;
               nxt_dx_oe = 1'b1;
               nxt_bits = '0;
               nxt_state = scs_pkg::ST_SLAVE;
            end
         end
         scs_pkg::ST_ARM:
         begin
            if (!run_master)
               nxt_state = scs_pkg::ST_IDLE;
            else if (m_start)
            begin
               nxt_fs_act = 1'b1;
               fifo_pop = 1'b1;
               nxt_tx_sh = fifo_data;
               nxt_edge = '0;
               nxt_state = scs_pkg::ST_MASTER;
            end
         end
         scs_pkg::ST_MASTER:
         begin
            if (m_lead | m_trail)
            begin
               nxt_edge = e_n;
               nxt_sclk = (in_win && m_lead) ? ~pol : pol;
               if (e_n[0] && e_n != E_FLOAT)
               begin
                  // Odd edges before the float edge shift; in half-delay the first is mid-lead-in
                  nxt_dx = tx_sh_ff[WORD_BITS-1];
                  nxt_tx_sh = tx_sh_ff << 1;
                  nxt_dx_oe = 1'b1;
               end
               else if (e_n[0])
                  nxt_dx_oe = 1'b0;
               else if (e_n <= E_LAST_SMP)
               begin
                  nxt_rx_sh = {rx_sh_ff[WORD_BITS-2:0], serial_receive_pin};
                  if (e_n == E_LAST_SMP)
                  begin
                     nxt_rx_word = nxt_rx_sh;
                     nxt_rx_valid = 1'b1;
                  end
               end
               else
               begin
                  // The select is released one phase after the last clock edge in half-delay, two phases after it in no-delay
                  nxt_fs_act = 1'b0;
                  nxt_state = scs_pkg::ST_IDLE;
               end
            end
         end
         scs_pkg::ST_SLAVE:
         begin
            if (!sel_tx || !run_slave)
            begin
               nxt_dx_oe = 1'b0;
               nxt_state = scs_pkg::ST_IDLE;
            end
            else
            begin
               if (s_sample && sel_rx && bit_cnt_ff != B_ALL)
               begin
                  nxt_rx_sh = {rx_sh_ff[WORD_BITS-2:0], dr_s_ff};
                  nxt_bits = bit_cnt_ff + BC_W'(1);
                  if (bit_cnt_ff == B_LAST)
                  begin
                     nxt_rx_word = nxt_rx_sh;
                     nxt_rx_valid = 1'b1;
                  end
               end
               if (s_shift && half_mode && bit_cnt_ff == B_ALL)
                  nxt_dx_oe = 1'b0;
               else if (s_shift && bit_cnt_ff != B_ALL)
               begin
                  nxt_dx = tx_sh_ff[WORD_BITS-1];
                  nxt_tx_sh = tx_sh_ff << 1;
               end
            end
         end
         default:
            nxt_state = scs_pkg::ST_IDLE;
      endcase
   end

   // ==========
   // Sequencer registers
   // ==========
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         state_ff <= scs_pkg::ST_IDLE;
         tx_sh_ff <= '0;
         rx_sh_ff <= '0;
         edge_cnt_ff <= '0;
         bit_cnt_ff <= '0;
         fs_act_ff <= 1'b0;
      end
      else if (ce)
      begin
         state_ff <= nxt_state;
         tx_sh_ff <= nxt_tx_sh;
         rx_sh_ff <= nxt_rx_sh;
         edge_cnt_ff <= nxt_edge;
         bit_cnt_ff <= nxt_bits;
         fs_act_ff <= nxt_fs_act;
      end
   end

   // ==========
   // Output registers
   // ==========
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
      begin
         dx_ff <= scs_pkg::RST_PIN_LEVEL;
         serial_transmit_pin_oe <= scs_pkg::RST_PIN_OE;
         tx_bit_clock_pin_o <= scs_pkg::RST_PIN_LEVEL;
         tx_bit_clock_pin_oe <= scs_pkg::RST_PIN_OE;
         tx_frame_sync_pin_o <= scs_pkg::RST_PIN_LEVEL;
         tx_frame_sync_pin_oe <= scs_pkg::RST_PIN_OE;
         rx_word <= '0;
         rx_word_valid <= 1'b0;
         busy <= 1'b0;
         config_error <= 1'b0;
      end
      else if (ce)
      begin
         dx_ff <= nxt_dx;
         serial_transmit_pin_oe <= nxt_dx_oe;
         tx_bit_clock_pin_o <= nxt_sclk;
         tx_bit_clock_pin_oe <= run_master;
         tx_frame_sync_pin_o <= nxt_fs_act ^ tx_sync_polarity;
         tx_frame_sync_pin_oe <= run_master;
         rx_word <= nxt_rx_word;
         rx_word_valid <= nxt_rx_valid;
         busy <= (nxt_state != scs_pkg::ST_IDLE);
         config_error <= port_enable & ~(run_master | run_slave);
      end
   end

   assign serial_transmit_pin_o = dx_ff;

endmodule : scs_spi_top

`default_nettype wire

// ===== verification/scs_spi_monitor.sv
// Purpose: Pin assertions for the clock-stop serial port
// Assumes: Master checks use divider 1 or 2; ce high
// Notes: Bound to every top instance
`timescale 1ns/1ps
`default_nettype none
module scs_spi_monitor #(
   parameter int DIV_W = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic port_enable,
   input wire logic [1:0] clock_halt_mode,
   input wire logic tx_clock_polarity,
   input wire logic tx_clock_direction,
   input wire logic rx_clock_direction,
   input wire logic tx_sync_direction,
   input wire logic rx_sync_direction,
   input wire logic tx_sync_polarity,
   input wire logic rate_gen_source_select,
   input wire logic [DIV_W-1:0] clock_divide_value,
   input wire logic busy,
   input wire logic serial_transmit_pin_oe,
   input wire logic tx_bit_clock_pin_o,
   input wire logic tx_bit_clock_pin_oe,
   input wire logic tx_frame_sync_pin_o,
   input wire logic tx_frame_sync_pin_oe
);
   // ==========
   // Decode
   // ==========
   logic [2:0] up_ff;
   // Skip the reset synchroniser edges
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
         up_ff <= 3'h0;
      else if (up_ff != 3'h7)
         up_ff <= up_ff + 3'h1;
   end
   // Mode qualifiers
   wire logic ok = (up_ff == 3'h7);
   wire logic c = tx_bit_clock_pin_o;
   wire logic f = tx_frame_sync_pin_o;
   wire logic p = tx_clock_polarity;
   wire logic sl = !(tx_clock_direction | rx_clock_direction | tx_sync_direction | rx_sync_direction);
   wire logic dm = tx_clock_direction & tx_sync_direction & !rx_clock_direction & !rx_sync_direction;
   wire logic m = ok & port_enable & clock_halt_mode[1] & dm;
   wire logic h = m & clock_halt_mode[0];
   wire logic d1 = m & tx_sync_polarity & rate_gen_source_select & (clock_divide_value == DIV_W'(1));
   wire logic h1 = d1 & clock_halt_mode[0];
   wire logic d2 = h & !p & rate_gen_source_select & (clock_divide_value == DIV_W'(2));
   // ==========
   // Checks
   // ==========
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   chk_idle_clock: assert property (m && $past(m) && !busy && !$past(busy) && $stable(p) |-> c == p)
      else $error("clock moved while idle");
   chk_slave_pins: assert property (ok && sl && $past(sl) |-> !tx_bit_clock_pin_oe && !tx_frame_sync_pin_oe)
      else $error("slave drives clock");
   chk_select_lead: assert property (h1 && $fell(f) |-> ##1 $stable(c) ##1 $changed(c))
      else $error("select lead wrong");
   chk_first_bit: assert property (h1 && $fell(f) |-> ##1 serial_transmit_pin_oe && c == p)
      else $error("first bit late");
   chk_select_hold: assert property (h1 && !p && $rose(f) |-> !$past(c) && $past(c, 2))
      else $error("select hold wrong");
   chk_nodelay_lead: assert property (d1 && !clock_halt_mode[0] && p && $fell(f) |-> c ##1 $fell(c))
      else $error("no-delay lead wrong");
   chk_release_edge: assert property (h && $fell(serial_transmit_pin_oe) |-> $changed(c) && c == p)
      else $error("data release off edge");
   chk_phase_two: assert property (d2 && $rose(c) |-> ##1 c ##1 !c ##1 (c || !serial_transmit_pin_oe))
      else $error("phase width wrong");
   cov_half_word: cover property (h && $fell(serial_transmit_pin_oe));
   cov_nodelay_word: cover property (d1 && !clock_halt_mode[0] && $fell(f));
   cov_slave_cfg: cover property (ok && sl);
endmodule : scs_spi_monitor
bind scs_spi_top scs_spi_monitor #(.DIV_W(DIV_W)) u_scs_spi_monitor (.*);
`default_nettype wire

// ===== verification/scs_spi_slave_model.sv
// Purpose: Far-side peripheral for master transfers
// Assumes: Select active low; flip swaps the capture edge
// Notes: Released data line shows its last bit inverted
`timescale 1ns/1ps
`default_nettype none
module scs_spi_slave_model (
   input wire logic sclk,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic flip,
   input wire logic [7:0] reply,
   output logic miso,
   output logic [7:0] got
);
   // ==========
   // Shifter
   // ==========
   logic [7:0] sh = 8'h00;
   int n = 0;
   wire logic k = sclk ^ flip;
   // No shift before first capture, so bit 7 survives a leading edge
   always @(negedge sel_n) sh = reply;
   always @(negedge sel_n) n = 0;
   always @(posedge k) if (!sel_n) got = {got[6:0], mosi};
   always @(posedge k) if (!sel_n) n++;
   always @(negedge k) if (!sel_n && n > 0) sh = {sh[6:0], 1'b0};
   assign miso = sel_n ? ~sh[7] : sh[7];
endmodule : scs_spi_slave_model
`default_nettype wire

// ===== verification/scs_spi_top_tb.sv
// Purpose: Self-checking bench for the clock-stop serial port
// Assumes: Master pins loop back to receive clock and sync
// Notes: Slave set-up checked at its pins only
`timescale 1ns/1ps
`default_nettype none
module scs_spi_top_tb;
   // ==========
   // Wiring
   // ==========
   logic clk = 1'b0, reset_n = 1'b0, ce = 1'b1, port_enable = 1'b0, ext_rate_clock_pin = 1'b0, tx_word_valid = 1'b0;
   logic tx_clock_polarity = 1'b0, rate_gen_source_select = 1'b1, tx_sync_polarity = 1'b1, rx_sync_polarity = 1'b1;
   logic tx_clock_direction = 1'b1, tx_sync_direction = 1'b1, rx_clock_direction = 1'b0, rx_sync_direction = 1'b0;
   logic [1:0] clock_halt_mode = 2'h3;
   logic [7:0] clock_divide_value = 8'h01, tx_word = 8'h00, reply = 8'h00, rx_word, got, last_rx;
   logic tx_word_ready, rx_word_valid, busy, config_error, serial_transmit_pin_o, serial_transmit_pin_oe;
   logic tx_bit_clock_pin_o, tx_bit_clock_pin_oe, tx_frame_sync_pin_o, tx_frame_sync_pin_oe;
   int failures = 0, tests_run = 0, nrx = 0;
   wire logic serial_receive_pin;
   // Undriven clock idles at polarity; select and data pull high
   wire logic tx_bit_clock_pin_i = tx_bit_clock_pin_oe ? tx_bit_clock_pin_o : tx_clock_polarity;
   wire logic tx_frame_sync_pin_i = tx_frame_sync_pin_oe ? tx_frame_sync_pin_o : 1'b1;
   wire logic rx_bit_clock_pin = tx_bit_clock_pin_i;
   wire logic rx_frame_sync_pin = tx_frame_sync_pin_i;
   wire logic mosi = serial_transmit_pin_oe ? serial_transmit_pin_o : 1'b1;
   scs_spi_top u_scs_spi_top (.*);
   scs_spi_slave_model u_scs_spi_slave_model (.sclk(tx_bit_clock_pin_i), .sel_n(tx_frame_sync_pin_i), .mosi(mosi),
      .flip(clock_halt_mode[0] & tx_clock_polarity), .reply(reply), .miso(serial_receive_pin), .got(got));
   always #10 clk = ~clk;
   // One rate tick every two cycles
   always @(posedge clk) ext_rate_clock_pin <= ~ext_rate_clock_pin;
   // Valid lasts one cycle, so latch the word here
   always @(posedge clk)
   begin
      if (rx_word_valid === 1'b1) last_rx = rx_word;
      if (rx_word_valid === 1'b1) nrx++;
   end
   // ==========
   // Tasks
   // ==========
   task automatic chk(input logic [7:0] a, input logic [7:0] e);
      tests_run++;
      if (a !== e) failures++;
      if (a !== e) $display("[FAIL] %0t seen %h want %h", $time, a, e);
   endtask : chk
   task automatic test_done;
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : test_done
   task automatic push(input logic [7:0] w);
      logic r;
      tx_word <= w;
      tx_word_valid <= 1'b1;
      do
      begin
         @(negedge clk) r = tx_word_ready;
         @(posedge clk);
      end while (r !== 1'b1);
      tx_word_valid <= 1'b0;
      @(posedge clk);
   endtask : push
   task automatic settle(input int n);
      repeat (2000) if (nrx < n || busy !== 1'b0) @(posedge clk);
   endtask : settle
   task automatic t_m(input logic [1:0] md, input logic p, s, input logic [7:0] d, w, q);
      clock_halt_mode <= md;
      tx_clock_polarity <= p;
      rate_gen_source_select <= s;
      clock_divide_value <= d;
      reply <= q;
      port_enable <= 1'b1;
      repeat (3) @(posedge clk);
      push(w);
      settle(nrx + 1);
      chk(last_rx, q);
      chk(got, w);
      $display("master test done, mode %h", md);
   endtask : t_m
   task automatic t_fill;
      port_enable <= 1'b0;
      reply <= 8'h55;
      for (int i = 0; i < 8; i++) push(8'h10 + 8'(i));
      @(negedge clk) chk(tx_word_ready, 1'b0);
      chk(busy, 1'b0);
      @(posedge clk) port_enable <= 1'b1;
      settle(nrx + 8);
      chk(got, 8'h17);
      chk(tx_word_ready, 1'b1);
      $display("fill test done");
   endtask : t_fill
   task automatic t_cfg;
      {tx_clock_direction, tx_sync_direction} <= 2'h0;
      repeat (3) @(posedge clk);
      @(negedge clk) chk(tx_bit_clock_pin_oe, 1'b0);
      chk(tx_frame_sync_pin_oe, 1'b0);
      @(posedge clk) tx_clock_direction <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk) chk(config_error, 1'b1);
      $display("config test done");
   endtask : t_cfg
   // ==========
   // Sequence
   // ==========
   initial
   begin
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (4) @(posedge clk);
      t_m(2'h3, 1'b0, 1'b1, 8'h01, 8'hA5, 8'h3C);
      t_m(2'h2, 1'b1, 1'b1, 8'h01, 8'h5A, 8'hC3);
      t_m(2'h3, 1'b1, 1'b1, 8'h01, 8'h96, 8'h69);
      t_m(2'h3, 1'b0, 1'b1, 8'h02, 8'hF0, 8'h0F);
      t_m(2'h3, 1'b0, 1'b0, 8'h01, 8'h81, 8'h7E);
      t_fill;
      t_cfg;
      test_done;
   end
   // Watchdog well past the expected run
   initial
   begin
      #60000;
      failures++;
      test_done;
   end
endmodule : scs_spi_top_tb
`default_nettype wire
